// File: jnac_claim.v
// Chosen here: the register offsets and the APB slave port.
`timescale 1ns/100ps
`include "jnac_regs.vh"
// Functional notes
// - claim address before any application traffic
// - fixed name fields, aac one, func 66/14
// - 21-bit identity from unique id, read-only
// - programmable 3-bit ecu instance, default 0
// - address default 151, range 0 to 253
// - change address on loss or command
// - store changed address to non-volatile memory
// - 250k units select slew, slow default
// - faster units force fast slew
// - serve memory access setpoint reads, writes
// - reset function blocks after setpoint change
// - identity change reruns claim, new name
// - bulk transfer skips identity, read-only settings
// - send claims, answer requests, accept commands
module jnac_claim #(
    parameter [1:0]  BAUD_SEL   = 2'd0,   // 0: 250k, 1: 500k, 2: 1M
    parameter [10:0] MAKER      = 11'd5,  // arbitrary value
    parameter [20:0] UNIQUE_ID  = 21'h0_1234,
    parameter        CLAIM_WAIT = `JNAC_CLAIM_WAIT_MS * (`JNAC_CLK_KHZ)
) (
    input  wire        CLK,
    input  wire        RESETN,
    input  wire        PSEL,
    input  wire        PENABLE,
    input  wire        PWRITE,
    input  wire [11:0] PADDR,
    input  wire [31:0] PWDATA,
    output reg  [31:0] PRDATA,
    output reg         PREADY,
    output reg         PSLVERR,
    output reg         TX_CLAIM,
    output reg  [7:0]  TX_SA,
    output reg  [17:0] TX_PGN,
    output reg         APP_ENABLE,
    output reg         FB_RESET,
    output reg         NV_WRITE,
    output reg  [7:0]  NV_ADDR,
    output reg         SLEW_FAST
);

    localparam ST_IDLE  = 2'd0;
    localparam ST_SEND  = 2'd1;
    localparam ST_WAIT  = 2'd2;
    localparam ST_OK    = 2'd3;

    reg  [1:0]  state;
    reg  [31:0] wait_cnt;
    reg  [7:0]  addr;
    reg  [2:0]  ecu_inst;
    reg         slew_sel;
    reg         bulk;
    reg         failed;
    reg  [9:0]  rx_msg;
    reg  [63:0] rx_name;
    reg         rx_go;
    reg         restart;
    wire [63:0] name;
    wire        wr = PSEL & PENABLE & PWRITE & PREADY;
    wire        rd_setup = PSEL & ~PENABLE;
    wire        high_baud = (BAUD_SEL != 2'd0);
    wire [7:0]  rx_sa = rx_msg[`JNAC_RX_SA_LSB +: 8];
    wire [1:0]  rx_kind = rx_msg[`JNAC_RX_KIND_LSB +: 2];
    wire        cfg_hit = wr & (PADDR == `JNAC_OFF_CFG);
    wire        in_range = (PWDATA[7:0] <= `JNAC_ADDR_MAX);

    // identity number is a fixed strap, no write path exists
    jnac_name #(
        .MAKER    (MAKER)
    ) u_name (
        .identity (UNIQUE_ID),
        .ecu_inst (ecu_inst),
        .name     (name)
    );

    // apb slave: no wait states, unmapped gives error
    always @(posedge CLK) begin
        if (!RESETN) begin
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA  <= 32'h0000_0000;
        end else begin
            PREADY  <= rd_setup;
            PSLVERR <= 1'b0;
            if (rd_setup) begin
                case (PADDR)
                    `JNAC_OFF_CTRL:      PRDATA <= 32'h0000_0000;
                    `JNAC_OFF_STATUS:    PRDATA <= {28'h000_0000, failed, APP_ENABLE, state};
                    `JNAC_OFF_CFG:       PRDATA <= {20'h0_0000, slew_sel, ecu_inst, addr};
                    `JNAC_OFF_NAME_LO:   PRDATA <= name[31:0];
                    `JNAC_OFF_NAME_HI:   PRDATA <= name[63:32];
                    `JNAC_OFF_RXMSG:     PRDATA <= {22'h00_0000, rx_msg};
                    `JNAC_OFF_RXNAME_LO: PRDATA <= rx_name[31:0];
                    `JNAC_OFF_RXNAME_HI: PRDATA <= rx_name[63:32];
                    `JNAC_OFF_NVADDR:    PRDATA <= {24'h00_0000, NV_ADDR};
                    `JNAC_OFF_BULK:      PRDATA <= {31'h0000_0000, bulk};
                    default: begin
                        PRDATA  <= 32'h0000_0000;
                        PSLVERR <= 1'b1;
                    end
                endcase
            end
        end
    end

    // setpoint registers; software is the memory-access server's back end
    always @(posedge CLK) begin
        if (!RESETN) begin
            ecu_inst <= `JNAC_INST_RST;
            slew_sel <= 1'b0;           // slow default
            bulk     <= 1'b0;
            rx_msg   <= 10'd0;
            rx_name  <= 64'h0000_0000_0000_0000;
            rx_go    <= 1'b0;
            restart  <= 1'b0;
        end else begin
            rx_go   <= 1'b0;
            restart <= 1'b0;
            if (wr && PADDR == `JNAC_OFF_BULK)
                bulk <= PWDATA[0];
            if (wr && PADDR == `JNAC_OFF_RXNAME_LO)
                rx_name[31:0] <= PWDATA;
            if (wr && PADDR == `JNAC_OFF_RXNAME_HI)
                rx_name[63:32] <= PWDATA;
            if (wr && PADDR == `JNAC_OFF_RXMSG) begin
                rx_msg <= PWDATA[9:0];
                rx_go  <= 1'b1;
            end
            if (wr && PADDR == `JNAC_OFF_CTRL && PWDATA[0])
                restart <= 1'b1;
            // identity fields are locked during bulk transfer
            if (cfg_hit && !bulk) begin
                slew_sel <= PWDATA[`JNAC_CFG_SLEW_BIT] & ~high_baud;
                if (PWDATA[`JNAC_CFG_INST_LSB +: 3] != ecu_inst)
                    restart <= 1'b1; // new name needs a new claim
                ecu_inst <= PWDATA[`JNAC_CFG_INST_LSB +: 3];
            end else if (cfg_hit) begin
                slew_sel <= PWDATA[`JNAC_CFG_SLEW_BIT] & ~high_baud;
            end
        end
    end

    // claim state machine, address and nv storage
    always @(posedge CLK) begin
        if (!RESETN) begin
            state      <= ST_IDLE;
            wait_cnt   <= 32'd0;
            addr       <= `JNAC_ADDR_RST;
            failed     <= 1'b0;
            TX_CLAIM   <= 1'b0;
            TX_SA      <= 8'd0;
            TX_PGN     <= 18'd0;
            APP_ENABLE <= 1'b0;
            FB_RESET   <= 1'b0;
            NV_WRITE   <= 1'b0;
            NV_ADDR    <= `JNAC_ADDR_RST;
            SLEW_FAST  <= 1'b0;
        end else begin
            TX_CLAIM  <= 1'b0;
            NV_WRITE  <= 1'b0;
            FB_RESET  <= cfg_hit; // every setpoint write resets blocks
            SLEW_FAST <= high_baud | slew_sel;
            // address written by software is a setpoint change
            if (cfg_hit && !bulk && in_range && PWDATA[7:0] != addr) begin
                addr     <= PWDATA[7:0];
                NV_WRITE <= 1'b1;
                NV_ADDR  <= PWDATA[7:0];
                state    <= ST_IDLE;
                APP_ENABLE <= 1'b0;
            end else if (restart) begin
                state      <= ST_IDLE;
                APP_ENABLE <= 1'b0;
            end else if (rx_go && rx_kind == `JNAC_KIND_COMMAND
                         && rx_sa <= `JNAC_ADDR_MAX) begin
                addr       <= rx_sa; // commanded address
                NV_WRITE   <= 1'b1;
                NV_ADDR    <= rx_sa;
                state      <= ST_IDLE;
                APP_ENABLE <= 1'b0;
            end else if (rx_go && rx_kind == `JNAC_KIND_REQUEST) begin
                TX_CLAIM <= 1'b1; // answer request for claim
                TX_SA    <= failed ? `JNAC_ADDR_NULL : addr;
                TX_PGN   <= `JNAC_PGN_CLAIM;
            end else if (rx_go && rx_kind == `JNAC_KIND_CLAIM && rx_sa == addr
                         && !failed) begin
                if (rx_name < name) begin
                    // lost: move up to next address, give up when already at address 253
                    APP_ENABLE <= 1'b0;
                    if (addr == `JNAC_ADDR_MAX) begin
                        failed   <= 1'b1;
                        TX_CLAIM <= 1'b1; // cannot-claim notice
                        TX_SA    <= `JNAC_ADDR_NULL;
                        TX_PGN   <= `JNAC_PGN_CLAIM;
                        state    <= ST_OK;
                    end else begin
                        addr     <= addr + 8'd1;
                        NV_WRITE <= 1'b1;
                        NV_ADDR  <= addr + 8'd1;
                        state    <= ST_IDLE;
                    end
                end else begin
                    TX_CLAIM <= 1'b1; // we win, defend the address
                    TX_SA    <= addr;
                    TX_PGN   <= `JNAC_PGN_CLAIM;
                end
            end else begin
                case (state)
                    ST_IDLE: begin
                        failed <= 1'b0;
                        state  <= ST_SEND;
                    end
                    ST_SEND: begin
                        TX_CLAIM <= 1'b1;
                        TX_SA    <= addr;
                        TX_PGN   <= `JNAC_PGN_CLAIM;
                        wait_cnt <= 32'd0;
                        state    <= ST_WAIT;
                    end
                    ST_WAIT: begin
                        // no application traffic until contention window passes
                        if (wait_cnt >= CLAIM_WAIT - 1) begin
                            APP_ENABLE <= 1'b1;
                            state      <= ST_OK;
                        end else begin
                            wait_cnt <= wait_cnt + 32'd1;
                        end
                    end
                    ST_OK: begin
                        state <= ST_OK;
                    end
                    default: state <= ST_IDLE;
                endcase
            end
        end
    end
endmodule

// File: jnac_claim_checker.sv
`timescale 1ns/100ps
`include "jnac_regs.vh"
module jnac_claim_checker #(
    parameter [1:0] BAUD_SEL = 2'd0
) (
    input wire        CLK,
    input wire        RESETN,
    input wire        PSEL,
    input wire        PENABLE,
    input wire        PWRITE,
    input wire [11:0] PADDR,
    input wire        PREADY,
    input wire        PSLVERR,
    input wire        TX_CLAIM,
    input wire [7:0]  TX_SA,
    input wire [17:0] TX_PGN,
    input wire        APP_ENABLE,
    input wire        FB_RESET,
    input wire        NV_WRITE,
    input wire [7:0]  NV_ADDR,
    input wire        SLEW_FAST
);
    reg  [7:0] last_nv;
    wire       acc = PSEL && PENABLE && PREADY;
    // keep the stored address so the claim that follows can be matched to it
    always @(posedge CLK) begin
        if (NV_WRITE) begin
            last_nv <= NV_ADDR;
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence s_setup; PSEL && !PENABLE; endsequence
    sequence s_cfg_wr; acc && PWRITE && PADDR == `JNAC_OFF_CFG; endsequence
    property p_ready; s_setup |=> PREADY; endproperty
    property p_slverr; acc && PADDR > `JNAC_OFF_BULK |-> PSLVERR; endproperty
    property p_fbrst; s_cfg_wr |=> FB_RESET; endproperty
    property p_quiet; $rose(RESETN) |-> !APP_ENABLE [*8]; endproperty
    property p_boot; $rose(RESETN) |-> ##[1:3] TX_CLAIM; endproperty
    property p_pgn; TX_CLAIM |-> TX_PGN == `JNAC_PGN_CLAIM; endproperty
    property p_nvrange; NV_WRITE |-> NV_ADDR <= `JNAC_ADDR_MAX; endproperty
    property p_nvclaim; NV_WRITE |=> ##[0:8] (TX_CLAIM && TX_SA == last_nv); endproperty
    // the slew pin lags reset by one cycle, hence the past term
    property p_slew; BAUD_SEL != 2'd0 && $past(RESETN) |-> SLEW_FAST; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    a_slverr: assert property (p_slverr) else $error("no slave error");
    a_fbrst: assert property (p_fbrst) else $error("no block reset");
    a_quiet: assert property (p_quiet) else $error("traffic before claim");
    a_boot: assert property (p_boot) else $error("no claim after reset");
    a_pgn: assert property (p_pgn) else $error("bad group number");
    a_nvrange: assert property (p_nvrange) else $error("stored address out of range");
    a_nvclaim: assert property (p_nvclaim) else $error("no claim of new address");
    a_slew: assert property (p_slew) else $error("slow slew on fast unit");
endmodule

// File: jnac_name.v
`timescale 1ns/100ps
// assembles the 64-bit network identity from fixed and programmable fields
module jnac_name #(
    parameter MAKER = 11'd5
) (
    input  wire [20:0] identity,
    input  wire [2:0]  ecu_inst,
    output wire [63:0] name
);
`include "jnac_regs.vh"
    // msb first: aac, industry, vsys inst, vsys, reserved, func, inst, ecu, maker, id
    assign name = {`JNAC_AAC, 3'd0, 4'd0, 7'd0, 1'b0, `JNAC_FUNC_CODE,
                   `JNAC_FUNC_INST, ecu_inst, MAKER, identity};
endmodule

// File: jnac_peer.sv
`timescale 1ns/100ps
// far side: peers hearing our claims, plus the non-volatile address store
module jnac_peer (
    input wire        clk,
    input wire        tx_claim,
    input wire [7:0]  tx_sa,
    input wire        nv_write,
    input wire [7:0]  nv_addr,
    output reg [7:0]  heard_sa,
    output reg [7:0]  stored,
    output reg [31:0] claims
);
    initial begin
        heard_sa = 8'hff;
        stored = 8'h97;
        claims = 32'h0000_0000;
    end
    // frames are one cycle wide, so each is taken at the edge where it stands
    always @(posedge clk) begin
        if (tx_claim) begin
            heard_sa <= tx_sa;
            claims <= claims + 1;
        end
        if (nv_write) begin
            stored <= nv_addr;
        end
    end
endmodule

// File: jnac_regs.vh
`ifndef JNAC_REGS_VH
`define JNAC_REGS_VH
// register byte offsets
`define JNAC_OFF_CTRL      12'h000
`define JNAC_OFF_STATUS    12'h004
`define JNAC_OFF_CFG       12'h008
`define JNAC_OFF_NAME_LO   12'h00C
`define JNAC_OFF_NAME_HI   12'h010
`define JNAC_OFF_RXMSG     12'h014
`define JNAC_OFF_RXNAME_LO 12'h018
`define JNAC_OFF_RXNAME_HI 12'h01C
`define JNAC_OFF_NVADDR    12'h020
`define JNAC_OFF_BULK      12'h024
// cfg fields
`define JNAC_CFG_ADDR_LSB  0
`define JNAC_CFG_INST_LSB  8
`define JNAC_CFG_SLEW_BIT  11
// rx message fields
`define JNAC_RX_SA_LSB     0
`define JNAC_RX_KIND_LSB   8
// rx kinds
`define JNAC_KIND_CLAIM    2'd1
`define JNAC_KIND_REQUEST  2'd2
`define JNAC_KIND_COMMAND  2'd3
// name constants
`define JNAC_FUNC_CODE     8'd66
`define JNAC_FUNC_INST     5'd14
`define JNAC_AAC           1'b1
// parameter group numbers
`define JNAC_PGN_CLAIM     18'd60928
`define JNAC_PGN_REQUEST   18'd59904
`define JNAC_PGN_COMMAND   18'd65240
// reset values and address limits
`define JNAC_ADDR_RST      8'd151
`define JNAC_ADDR_MAX      8'd253
`define JNAC_ADDR_NULL     8'd254
`define JNAC_INST_RST      3'd0
// claim wait: 250 ms at 125 MHz
`define JNAC_CLAIM_WAIT_MS 250
`define JNAC_CLK_KHZ       125000
`endif

// File: testbench.sv
`timescale 1ns/100ps
`include "jnac_regs.vh"
module testbench;
    reg         clk = 1'b0;
    reg         resetn = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0000_0000;
    reg  [31:0] rd, n;
    reg         err;
    wire [31:0] prdata, claims;
    wire [17:0] tx_pgn;
    wire [7:0]  tx_sa, nv_addr, heard_sa, stored;
    wire        pready, pslverr, tx_claim, app_enable, fb_reset, nv_write, slew_fast, fast_slew;
    integer     mismatches = 0;
    integer     comparisons = 0;
    integer     cycles = 0;
    always #4 clk = ~clk;
    jnac_claim #(.CLAIM_WAIT(20)) uut (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TX_CLAIM(tx_claim), .TX_SA(tx_sa), .TX_PGN(tx_pgn), .APP_ENABLE(app_enable),
        .FB_RESET(fb_reset), .NV_WRITE(nv_write), .NV_ADDR(nv_addr), .SLEW_FAST(slew_fast));
    // a faster-rate unit on the same bus, watched only at its slew pin
    jnac_claim #(.BAUD_SEL(2'd1), .CLAIM_WAIT(20)) uut_fast (
        .CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(), .PREADY(), .PSLVERR(), .TX_CLAIM(),
        .TX_SA(), .TX_PGN(), .APP_ENABLE(), .FB_RESET(), .NV_WRITE(), .NV_ADDR(),
        .SLEW_FAST(fast_slew));
    jnac_peer peer (.clk(clk), .tx_claim(tx_claim), .tx_sa(tx_sa), .nv_write(nv_write),
        .nv_addr(nv_addr), .heard_sa(heard_sa), .stored(stored), .claims(claims));
    task check(input [31:0] seen, input [31:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want) begin
                mismatches = mismatches + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
            end
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, mismatches);
            if (mismatches == 0 && comparisons > 0) begin
                $display("Regression OK");
            end else begin
                $display("Regression broken");
            end
            $finish;
        end
    endtask
    // one transfer; ready is sampled at the rising edge that ends the access phase
    task apb(input wr, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk);
            psel <= 1'b1;
            pwrite <= wr;
            paddr <= a;
            pwdata <= d;
            @(posedge clk);
            penable <= 1'b1;
            @(posedge clk);
            while (pready !== 1'b1) @(posedge clk);
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdchk(input [11:0] a, input [31:0] want);
        begin
            apb(1'b0, a, 32'h0000_0000);
            check(rd, want);
        end
    endtask
    // waits a bounded time for a claim frame beyond count c
    task claimed(input [31:0] c, input [7:0] sa);
        integer i;
        begin
            for (i = 0; i < 40 && claims == c; i = i + 1) @(posedge clk);
            check({heard_sa, claims != c}, {sa, 1'b1});
        end
    endtask
    // a hang is cut short here
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            mismatches = mismatches + 1;
            report_and_stop;
        end
    end
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        claimed(0, 8'h97);
        check(app_enable, 1'b0);
        repeat (24) @(posedge clk);
        check({app_enable, slew_fast, fast_slew}, 3'b101);
        rdchk(`JNAC_OFF_CFG, 32'h0000_0097);
        rdchk(`JNAC_OFF_NAME_HI, 32'h8000_4270);
        apb(1'b1, `JNAC_OFF_NAME_LO, 32'h0000_0000);
        rdchk(`JNAC_OFF_NAME_LO, 32'h00a0_1234);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        check({err, rd}, {1'b1, 32'h0000_0000});
        apb(1'b1, `JNAC_OFF_CFG, 32'h0000_00fe);
        rdchk(`JNAC_OFF_CFG, 32'h0000_0097);
        n = claims;
        apb(1'b1, `JNAC_OFF_CFG, 32'h0000_0d97);
        claimed(n, 8'h97);
        rdchk(`JNAC_OFF_NAME_HI, 32'h8000_4275);
        apb(1'b1, `JNAC_OFF_CFG, 32'h0000_0597);
        rdchk(`JNAC_OFF_CFG, 32'h0000_0597);
        check({slew_fast, fast_slew}, 2'b01);
        n = claims;
        apb(1'b1, `JNAC_OFF_RXMSG, 32'h0000_0200);
        claimed(n, 8'h97);
        apb(1'b1, `JNAC_OFF_RXNAME_LO, 32'h0000_0000);
        apb(1'b1, `JNAC_OFF_RXNAME_HI, 32'h0000_0000);
        n = claims;
        apb(1'b1, `JNAC_OFF_RXMSG, 32'h0000_0197);
        claimed(n, 8'h98);
        check(stored, 8'h98);
        apb(1'b1, `JNAC_OFF_RXNAME_HI, 32'hffff_ffff);
        n = claims;
        apb(1'b1, `JNAC_OFF_RXMSG, 32'h0000_0198);
        claimed(n, 8'h98);
        n = claims;
        apb(1'b1, `JNAC_OFF_RXMSG, 32'h0000_0320);
        claimed(n, 8'h20);
        check(stored, 8'h20);
        rdchk(`JNAC_OFF_CFG, 32'h0000_0520);
        rdchk(`JNAC_OFF_NVADDR, 32'h0000_0020);
        apb(1'b1, `JNAC_OFF_BULK, 32'h0000_0001);
        apb(1'b1, `JNAC_OFF_CFG, 32'h0000_0830);
        rdchk(`JNAC_OFF_CFG, 32'h0000_0d20);
        apb(1'b1, `JNAC_OFF_BULK, 32'h0000_0000);
        n = claims;
        apb(1'b1, `JNAC_OFF_CFG, 32'h0000_05fd);
        claimed(n, 8'hfd);
        apb(1'b1, `JNAC_OFF_RXNAME_HI, 32'h0000_0000);
        n = claims;
        apb(1'b1, `JNAC_OFF_RXMSG, 32'h0000_01fd);
        claimed(n, 8'hfe);
        apb(1'b0, `JNAC_OFF_STATUS, 32'h0000_0000);
        check(rd[3], 1'b1);
        report_and_stop;
    end
endmodule
bind jnac_claim jnac_claim_checker #(.BAUD_SEL(BAUD_SEL)) chk (.CLK(CLK), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .TX_CLAIM(TX_CLAIM), .TX_SA(TX_SA), .TX_PGN(TX_PGN),
    .APP_ENABLE(APP_ENABLE), .FB_RESET(FB_RESET), .NV_WRITE(NV_WRITE), .NV_ADDR(NV_ADDR),
    .SLEW_FAST(SLEW_FAST));
